/* File: design/gfc_defines.svh */
`ifndef GFC_DEFINES_SVH
`define GFC_DEFINES_SVH

// Printed byte offsets
`define GFC_OFF_LATENCY_TIMER 8'h0d
`define GFC_OFF_HEADER_LAYOUT 8'h0e
`define GFC_OFF_SELF_TEST 8'h0f
`define GFC_OFF_GFX_BASE 8'h10
`define GFC_OFF_WIN_BASE 8'h14
`define GFC_OFF_SUB_MAKER 8'h2c
`define GFC_OFF_SUB_IDENT 8'h2e
`define GFC_DWORD_MASK 8'hfc

// Hardwired and reset values
`define GFC_LATENCY_TIMER_VAL 8'h00
`define GFC_HEADER_LAYOUT_CODE 8'h00
`define GFC_SELF_TEST_VAL 8'h00
`define GFC_FOREIGN_BYTE 8'h00
`define GFC_GFX_BASE_RESET 32'h00000008
`define GFC_WIN_BASE_RESET 32'h00000000
`define GFC_SUB_RESET 16'h0000
`define GFC_GFX_PREFETCH 1'b1
`define GFC_WIN_PREFETCH 1'b0
`define GFC_MEM_TYPE_32 2'h0
`define GFC_SPACE_MEM 1'h0

// Field positions and widths
`define GFC_GFX_BASE_LO 26
`define GFC_GFX_BASE_W 6
`define GFC_GFX_MASK_BIT 25
`define GFC_WIN_BASE_LO 19
`define GFC_WIN_BASE_W 13
`define GFC_WIN_LANE2_LO 19
`define GFC_WIN_LANE2_W 5
`define GFC_LANE3_LO 24
`define GFC_LANE2_LO 16
`define GFC_DW_ADDR_W 6
`define GFC_BE_W 4
`define GFC_SUB_W 16

`endif

/* File: design/gfc_pkg.sv */
`include "gfc_defines.svh"

package gfc_pkg;

    // Configuration access from the host, one dword per request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`GFC_DW_ADDR_W-1:0] dword_addr;
        logic [`GFC_BE_W-1:0] be;
        logic [31:0] wdata;
    } gfc_cfg_req_t;

    typedef struct packed {
        logic valid;
        logic claimed;
        logic [31:0] rdata;
    } gfc_cfg_rsp_t;

    // Memory cycle address presented for range decode
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } gfc_mem_req_t;

    typedef struct packed {
        logic aperture_hit;
        logic window_hit;
    } gfc_mem_hit_t;

    typedef enum {
        GFC_SEL_NONE,
        GFC_SEL_ID,
        GFC_SEL_GFX,
        GFC_SEL_WIN,
        GFC_SEL_SUB
    } gfc_sel_t;

    typedef struct packed {
        logic [`GFC_GFX_BASE_W-1:0] gfx_base;
        logic gfx_mask;
        logic [`GFC_WIN_BASE_W-1:0] win_base;
        logic size_32mb;
        gfc_cfg_rsp_t rsp;
        gfc_mem_hit_t hit;
    } gfc_state_t;

endpackage

/* File: design/gfc_wonce_reg.sv */
`timescale 1ns/1ps
`default_nettype none

`include "gfc_defines.svh"

module gfc_wonce_reg #(
    parameter int WIDTH = `GFC_SUB_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic [WIDTH/8-1:0] i_be,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic [WIDTH-1:0] o_value,
    output logic o_locked
);

    typedef struct packed {
        logic [WIDTH-1:0] value;
        logic locked;
    } gfc_wonce_t;

    gfc_wonce_t state_q;
    gfc_wonce_t state_d;

    // ----------------------------------------
    // First write with any lane enabled stores and locks
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        if (i_wr && !state_q.locked && (|i_be)) begin
            for (int b = 0; b < WIDTH/8; b++) begin
                if (i_be[b]) begin
                    state_d.value[b*8 +: 8] = i_wdata[b*8 +: 8];
                end
            end
            state_d.locked = 1'b1;
        end
    end

    // Only reset reopens the register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q.value <= WIDTH'(`GFC_SUB_RESET);
            state_q.locked <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_value = state_q.value;
    assign o_locked = state_q.locked;

endmodule // gfc_wonce_reg

`default_nettype wire

/* File: design/gfc_config_header.sv */
// Operation
// - Latency timer always reads zero
// - Header layout reads fixed zero code
// - Self test capability bit reads zero
// - Aperture is 32 MB or 64 MB
// - Aperture base bits 31..26 writable, decoded
// - Bit 25 writable only in 32 MB mode
// - Aperture bits 24..4 read zero
// - Aperture bit 3 reads one, prefetchable
// - Aperture bits 2..1 read zero
// - Aperture register resets to 0x00000008
// - Window base bits 31..19 writable, decoded
// - Window bits 18..4 read zero
// - Window bits 3..1 zero, resets zero
// - Bit 0 of both bases reads zero
// - Maker ident accepts first write, locks
// - Subsystem ident accepts one write, locks
// - Only reset clears ident values, locks

`timescale 1ns/1ps
`default_nettype none

`include "gfc_defines.svh"

module gfc_config_header (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire gfc_pkg::gfc_cfg_req_t I_CFG_REQ,
    input wire logic I_APERTURE_SIZE_SELECT,
    input wire logic I_MEM_SPACE_EN,
    input wire gfc_pkg::gfc_mem_req_t I_MEM_REQ,
    output gfc_pkg::gfc_cfg_rsp_t O_CFG_RSP,
    output gfc_pkg::gfc_mem_hit_t O_MEM_HIT,
    output logic O_APERTURE_32MB,
    output logic [31:0] O_GFX_BASE,
    output logic [31:0] O_WIN_BASE,
    output logic [`GFC_SUB_W-1:0] O_SUB_MAKER,
    output logic [`GFC_SUB_W-1:0] O_SUB_IDENT,
    output logic [1:0] O_SUB_LOCKED
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [7:0] dword_of(input logic [7:0] off);
        dword_of = off & `GFC_DWORD_MASK;
    endfunction

    function automatic logic [1:0] lane_of(input logic [7:0] off);
        lane_of = off[1:0];
    endfunction

    // Maps a dword address onto the register it selects
    function automatic gfc_pkg::gfc_sel_t decode_sel(
        input logic [`GFC_DW_ADDR_W-1:0] dw
    );
        logic [7:0] byte_addr;
        byte_addr = {dw, 2'h0};
        if (byte_addr == dword_of(`GFC_OFF_LATENCY_TIMER)) begin
            decode_sel = gfc_pkg::GFC_SEL_ID;
        end else if (byte_addr == dword_of(`GFC_OFF_GFX_BASE)) begin
            decode_sel = gfc_pkg::GFC_SEL_GFX;
        end else if (byte_addr == dword_of(`GFC_OFF_WIN_BASE)) begin
            decode_sel = gfc_pkg::GFC_SEL_WIN;
        end else if (byte_addr == dword_of(`GFC_OFF_SUB_MAKER)) begin
            decode_sel = gfc_pkg::GFC_SEL_SUB;
        end else begin
            decode_sel = gfc_pkg::GFC_SEL_NONE;
        end
    endfunction

    // Places a byte in its lane of a dword
    function automatic logic [31:0] place_byte(
        input logic [7:0] off,
        input logic [7:0] val
    );
        place_byte = 32'h00000000;
        place_byte[lane_of(off)*8 +: 8] = val;
    endfunction

    // Places a halfword in its lane of a dword
    function automatic logic [31:0] place_half(
        input logic [7:0] off,
        input logic [15:0] val
    );
        place_half = 32'h00000000;
        place_half[lane_of(off)*8 +: 16] = val;
    endfunction

    // Aperture register as software sees it
    function automatic logic [31:0] gfx_view(
        input logic [`GFC_GFX_BASE_W-1:0] base,
        input logic mask_bit,
        input logic size_32mb
    );
        gfx_view = 32'h00000000;
        gfx_view[31:`GFC_GFX_BASE_LO] = base;
        gfx_view[`GFC_GFX_MASK_BIT] = size_32mb & mask_bit;
        gfx_view[3] = `GFC_GFX_PREFETCH;
        gfx_view[2:1] = `GFC_MEM_TYPE_32;
        gfx_view[0] = `GFC_SPACE_MEM;
    endfunction

    // Register window as software sees it
    function automatic logic [31:0] win_view(
        input logic [`GFC_WIN_BASE_W-1:0] base
    );
        win_view = 32'h00000000;
        win_view[31:`GFC_WIN_BASE_LO] = base;
        win_view[3] = `GFC_WIN_PREFETCH;
        win_view[2:1] = `GFC_MEM_TYPE_32;
        win_view[0] = `GFC_SPACE_MEM;
    endfunction

    // Aperture base and bit 25 after a write; only byte lane 3 carries them
    function automatic logic [`GFC_GFX_BASE_W:0] gfx_write(
        input logic [`GFC_GFX_BASE_W-1:0] base,
        input logic mask_bit,
        input logic size_32mb,
        input logic lane3_en,
        input logic [31:0] wdata
    );
        gfx_write = {base, mask_bit};
        if (lane3_en) begin
            gfx_write[`GFC_GFX_BASE_W:1] = wdata[31:`GFC_GFX_BASE_LO];
            // In the 64 MB mode bit 25 keeps what it stored
            if (size_32mb) begin
                gfx_write[0] = wdata[`GFC_GFX_MASK_BIT];
            end
        end
    endfunction

    // Window base after a write, merged lane by lane so a partial write keeps the rest
    function automatic logic [`GFC_WIN_BASE_W-1:0] win_write(
        input logic [`GFC_WIN_BASE_W-1:0] base,
        input logic [`GFC_BE_W-1:0] be,
        input logic [31:0] wdata
    );
        win_write = base;
        if (be[3]) begin
            win_write[`GFC_WIN_BASE_W-1:`GFC_WIN_LANE2_W] = wdata[31:`GFC_LANE3_LO];
        end
        if (be[2]) begin
            win_write[`GFC_WIN_LANE2_W-1:0] =
                wdata[`GFC_LANE3_LO-1:`GFC_WIN_LANE2_LO];
        end
    endfunction

    // Aperture claim: 64 MB compares bits 31..26, 32 MB adds bit 25
    function automatic logic aperture_match(
        input logic [31:0] addr,
        input logic [`GFC_GFX_BASE_W-1:0] base,
        input logic mask_bit,
        input logic size_32mb
    );
        aperture_match = (addr[31:`GFC_GFX_BASE_LO] == base);
        if (size_32mb) begin
            aperture_match = aperture_match
                && (addr[`GFC_GFX_MASK_BIT] == mask_bit);
        end
    endfunction

    // Register window claim over a fixed 512 KB range
    function automatic logic window_match(
        input logic [31:0] addr,
        input logic [`GFC_WIN_BASE_W-1:0] base
    );
        window_match = (addr[31:`GFC_WIN_BASE_LO] == base);
    endfunction

    // One answer per request; a write that also reads returns zero data
    function automatic gfc_pkg::gfc_cfg_rsp_t cfg_answer(
        input gfc_pkg::gfc_cfg_req_t req,
        input gfc_pkg::gfc_sel_t req_sel,
        input logic [31:0] word
    );
        cfg_answer = '0;
        cfg_answer.valid = req.wr || req.rd;
        cfg_answer.claimed = cfg_answer.valid && (req_sel != gfc_pkg::GFC_SEL_NONE);
        cfg_answer.rdata = (req.rd && !req.wr) ? word : 32'h00000000;
    endfunction

    // Read data of the selected dword; unmapped dwords read zero
    function automatic logic [31:0] read_word(
        input gfc_pkg::gfc_sel_t rsel,
        input gfc_pkg::gfc_state_t st,
        input logic [31:0] ids,
        input logic [`GFC_SUB_W-1:0] maker,
        input logic [`GFC_SUB_W-1:0] ident
    );
        case (rsel)
            gfc_pkg::GFC_SEL_ID: begin
                read_word = ids;
            end
            gfc_pkg::GFC_SEL_GFX: begin
                read_word = gfx_view(st.gfx_base, st.gfx_mask, st.size_32mb);
            end
            gfc_pkg::GFC_SEL_WIN: begin
                read_word = win_view(st.win_base);
            end
            gfc_pkg::GFC_SEL_SUB: begin
                read_word = place_half(`GFC_OFF_SUB_MAKER, maker)
                    | place_half(`GFC_OFF_SUB_IDENT, ident);
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    gfc_pkg::gfc_state_t state_q;
    gfc_pkg::gfc_state_t state_d;
    gfc_pkg::gfc_sel_t sel;
    logic [`GFC_SUB_W-1:0] sub_maker;
    logic [`GFC_SUB_W-1:0] sub_ident;
    logic maker_locked;
    logic ident_locked;
    logic sub_wr;
    logic [31:0] rd_word;
    logic [31:0] id_word;

    // One decode serves both the read mux and the write strobes
    assign sel = decode_sel(I_CFG_REQ.dword_addr);
    assign sub_wr = I_CFG_REQ.wr && (sel == gfc_pkg::GFC_SEL_SUB);

    // ----------------------------------------
    // Write-once subsystem identification
    // ----------------------------------------
    // Each half locks on its own first write; only reset reopens it
    gfc_wonce_reg #(
        .WIDTH(`GFC_SUB_W)
    ) u_sub_maker (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_wr(sub_wr),
        .i_be(I_CFG_REQ.be[lane_of(`GFC_OFF_SUB_MAKER) +: 2]),
        .i_wdata(I_CFG_REQ.wdata[lane_of(`GFC_OFF_SUB_MAKER)*8 +: 16]),
        .o_value(sub_maker),
        .o_locked(maker_locked)
    );

    gfc_wonce_reg #(
        .WIDTH(`GFC_SUB_W)
    ) u_sub_ident (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_wr(sub_wr),
        .i_be(I_CFG_REQ.be[lane_of(`GFC_OFF_SUB_IDENT) +: 2]),
        .i_wdata(I_CFG_REQ.wdata[lane_of(`GFC_OFF_SUB_IDENT)*8 +: 16]),
        .o_value(sub_ident),
        .o_locked(ident_locked)
    );

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Byte 0 of the dword at 0x0c belongs to another register
    always_comb begin
        id_word = place_byte(`GFC_OFF_LATENCY_TIMER, `GFC_LATENCY_TIMER_VAL);
        id_word = id_word
            | place_byte(`GFC_OFF_HEADER_LAYOUT, `GFC_HEADER_LAYOUT_CODE);
        id_word = id_word | place_byte(`GFC_OFF_SELF_TEST, `GFC_SELF_TEST_VAL);
        id_word[7:0] = `GFC_FOREIGN_BYTE;
    end

    always_comb begin
        rd_word = read_word(sel, state_q, id_word, sub_maker, sub_ident);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        // Sampled select keeps the read view and the decode in step
        state_d.size_32mb = I_APERTURE_SIZE_SELECT;

        // Writable base fields; everything else is hardwired
        if (I_CFG_REQ.wr) begin
            case (sel)
                gfc_pkg::GFC_SEL_GFX: begin
                    {state_d.gfx_base, state_d.gfx_mask} = gfx_write(state_q.gfx_base,
                        state_q.gfx_mask, I_APERTURE_SIZE_SELECT, I_CFG_REQ.be[3],
                        I_CFG_REQ.wdata);
                end
                gfc_pkg::GFC_SEL_WIN: begin
                    state_d.win_base = win_write(state_q.win_base, I_CFG_REQ.be,
                        I_CFG_REQ.wdata);
                end
                default: begin
                    state_d.gfx_base = state_q.gfx_base;
                end
            endcase
        end

        // One answer per request, a cycle later
        state_d.rsp = cfg_answer(I_CFG_REQ, sel, rd_word);

        // Memory range decode, against the bases as they stood before this edge
        state_d.hit.aperture_hit = I_MEM_REQ.valid && I_MEM_SPACE_EN
            && aperture_match(I_MEM_REQ.addr, state_q.gfx_base, state_q.gfx_mask,
                state_q.size_32mb);
        state_d.hit.window_hit = I_MEM_REQ.valid && I_MEM_SPACE_EN
            && window_match(I_MEM_REQ.addr, state_q.win_base);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Reset loads constants only; the select flop follows the pin one edge later
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_q.gfx_base <=
                `GFC_GFX_BASE_W'(`GFC_GFX_BASE_RESET >> `GFC_GFX_BASE_LO);
            state_q.gfx_mask <= 1'b0;
            state_q.win_base <=
                `GFC_WIN_BASE_W'(`GFC_WIN_BASE_RESET >> `GFC_WIN_BASE_LO);
            state_q.size_32mb <= 1'b0;
            state_q.rsp <= '0;
            state_q.hit <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Firmware is expected to write both idents once at boot
    assign O_CFG_RSP = state_q.rsp;
    assign O_MEM_HIT = state_q.hit;
    assign O_APERTURE_32MB = state_q.size_32mb;
    assign O_SUB_MAKER = sub_maker;
    assign O_SUB_IDENT = sub_ident;
    assign O_SUB_LOCKED = {ident_locked, maker_locked};

    // Base views rebuilt from flops only
    always_comb begin
        O_GFX_BASE = gfx_view(state_q.gfx_base, state_q.gfx_mask, state_q.size_32mb);
        O_WIN_BASE = win_view(state_q.win_base);
    end

endmodule // gfc_config_header

`default_nettype wire

/* File: tb/gfc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module gfc_host_model (
    input wire logic i_clk,
    input wire gfc_pkg::gfc_cfg_rsp_t i_rsp,
    output gfc_pkg::gfc_cfg_req_t o_req
);
    initial o_req = '0;

    // --------------------------------
    // One request, answer one cycle on
    // --------------------------------
    task automatic access(input logic wr, input logic rd, input logic [5:0] dw,
            input logic [3:0] be, input logic [31:0] wd, output gfc_pkg::gfc_cfg_rsp_t rsp);
        @(negedge i_clk);
        o_req = '{wr: wr, rd: rd, dword_addr: dw, be: be, wdata: wd};
        @(negedge i_clk);
        // The answer stands one cycle only, so take it before letting go
        rsp = i_rsp;
        // Released address, byte enable and data lines show the inverse, never a stale copy
        o_req = '{wr: 1'b0, rd: 1'b0, dword_addr: ~dw, be: ~be, wdata: ~wd};
    endtask
endmodule // gfc_host_model

`default_nettype wire

/* File: tb/gfc_header_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module gfc_header_props (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire gfc_pkg::gfc_cfg_req_t I_CFG_REQ,
    input wire logic I_APERTURE_SIZE_SELECT,
    input wire logic I_MEM_SPACE_EN,
    input wire gfc_pkg::gfc_mem_req_t I_MEM_REQ,
    input wire gfc_pkg::gfc_cfg_rsp_t O_CFG_RSP,
    input wire gfc_pkg::gfc_mem_hit_t O_MEM_HIT,
    input wire logic O_APERTURE_32MB,
    input wire logic [31:0] O_GFX_BASE,
    input wire logic [31:0] O_WIN_BASE,
    input wire logic [15:0] O_SUB_MAKER,
    input wire logic [15:0] O_SUB_IDENT,
    input wire logic [1:0] O_SUB_LOCKED
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    logic ap_exp;
    logic win_exp;
    logic [5:0] gfx_wd;
    logic [12:0] win_wd;
    logic [5:0] dw;
    assign dw = I_CFG_REQ.dword_addr;
    assign gfx_wd = I_CFG_REQ.wdata[31:26];
    assign win_wd = I_CFG_REQ.wdata[31:19];
    assign ap_exp = I_MEM_REQ.valid && I_MEM_SPACE_EN && I_MEM_REQ.addr[31:26] == O_GFX_BASE[31:26]
        && (!O_APERTURE_32MB || I_MEM_REQ.addr[25] == O_GFX_BASE[25]);
    assign win_exp = I_MEM_REQ.valid && I_MEM_SPACE_EN && I_MEM_REQ.addr[31:19] == O_WIN_BASE[31:19];

    a_hdr_reads_zero: assert property (
        I_CFG_REQ.rd && !I_CFG_REQ.wr && dw == 6'h03 |=> O_CFG_RSP.valid && O_CFG_RSP.rdata == 32'h0)
        else $error("header dword read not zero");
    a_gfx_low_fixed: assert property (
        O_GFX_BASE[24:0] == 25'h0000008 && (O_APERTURE_32MB || !O_GFX_BASE[25]))
        else $error("aperture fixed bits wrong");
    a_win_low_zero: assert property (O_WIN_BASE[18:0] == 19'h0)
        else $error("window fixed bits wrong");
    a_gfx_base_write: assert property (
        I_CFG_REQ.wr && dw == 6'h04 && I_CFG_REQ.be[3] |=> O_GFX_BASE[31:26] == $past(gfx_wd))
        else $error("aperture base not written");
    a_win_base_write: assert property (
        I_CFG_REQ.wr && dw == 6'h05 && I_CFG_REQ.be[3] && I_CFG_REQ.be[2]
        |=> O_WIN_BASE[31:19] == $past(win_wd)) else $error("window base not written");
    a_maker_lock_holds: assert property (
        O_SUB_LOCKED[0] |=> O_SUB_LOCKED[0] && $stable(O_SUB_MAKER))
        else $error("maker ident changed after lock");
    a_ident_lock_holds: assert property (
        O_SUB_LOCKED[1] |=> O_SUB_LOCKED[1] && $stable(O_SUB_IDENT))
        else $error("subsystem ident changed after lock");
    a_ap_decode: assert property (
        !$past(I_RST) |-> O_MEM_HIT.aperture_hit == $past(ap_exp))
        else $error("aperture decode wrong");
    a_win_decode: assert property (
        !$past(I_RST) |-> O_MEM_HIT.window_hit == $past(win_exp))
        else $error("window decode wrong");
    a_size_follow: assert property (
        !$past(I_RST) |-> O_APERTURE_32MB == $past(I_APERTURE_SIZE_SELECT))
        else $error("size select not followed");

    c_ap_hit: cover property (O_MEM_HIT.aperture_hit);
    c_win_hit: cover property (O_MEM_HIT.window_hit);
    c_locked: cover property (O_SUB_LOCKED == 2'b11);
endmodule // gfc_header_props

bind gfc_config_header gfc_header_props gfc_header_props_i (
    .I_REF_CLK, .I_RST, .I_CFG_REQ, .I_APERTURE_SIZE_SELECT, .I_MEM_SPACE_EN, .I_MEM_REQ,
    .O_CFG_RSP, .O_MEM_HIT, .O_APERTURE_32MB, .O_GFX_BASE, .O_WIN_BASE, .O_SUB_MAKER,
    .O_SUB_IDENT, .O_SUB_LOCKED
);

`default_nettype wire

/* File: tb/test_graphics_function_config_header.sv */
`timescale 1ns/1ps
`default_nettype none

module test_graphics_function_config_header;
    logic clk, rst, sel, en, ap32;
    gfc_pkg::gfc_cfg_req_t req;
    gfc_pkg::gfc_cfg_rsp_t rsp;
    gfc_pkg::gfc_mem_req_t mreq;
    gfc_pkg::gfc_mem_hit_t hit;
    logic [31:0] gbase, wbase;
    logic [15:0] smk, subsystem_ident;
    logic [1:0] lk;
    int err_count = 0;
    int check_count = 0;
    logic [5:0] m_gb;
    logic [12:0] m_wb;
    logic [31:0] m_sub;
    logic [1:0] m_lk;
    logic m_b25, m_sel;

    gfc_config_header gfc_config_header_i (.I_REF_CLK(clk), .I_RST(rst), .I_CFG_REQ(req),
        .I_APERTURE_SIZE_SELECT(sel), .I_MEM_SPACE_EN(en), .I_MEM_REQ(mreq), .O_CFG_RSP(rsp),
        .O_MEM_HIT(hit), .O_APERTURE_32MB(ap32), .O_GFX_BASE(gbase), .O_WIN_BASE(wbase),
        .O_SUB_MAKER(smk), .O_SUB_IDENT(subsystem_ident), .O_SUB_LOCKED(lk));
    gfc_host_model gfc_host_model_i (.i_clk(clk), .i_rsp(rsp), .o_req(req));

    // --------------------------------
    // Checking and reference model
    // --------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [31:0] m_rd(input logic [5:0] dw);
        case (dw)
            6'h04: return {m_gb, m_sel & m_b25, 25'h0000008};
            6'h05: return {m_wb, 19'h0};
            6'h0b: return m_sub;
            default: return 32'h0;
        endcase
    endfunction

    task automatic acc(input logic wr, input logic rd, input logic [5:0] dw, input logic [3:0] be,
            input logic [31:0] wd);
        gfc_pkg::gfc_cfg_rsp_t r;
        logic [31:0] e;
        e = (rd && !wr) ? m_rd(dw) : 32'h0;
        if (wr && dw == 6'h04 && be[3]) begin
            m_gb = wd[31:26];
            if (m_sel) m_b25 = wd[25];
        end
        if (wr && dw == 6'h05 && be[3]) m_wb[12:5] = wd[31:24];
        if (wr && dw == 6'h05 && be[2]) m_wb[4:0] = wd[23:19];
        for (int h = 0; h < 2; h++)
            if (wr && dw == 6'h0b && !m_lk[h] && be[2*h+:2] != 2'h0) begin
                for (int b = 2*h; b < 2*h+2; b++) if (be[b]) m_sub[8*b+:8] = wd[8*b+:8];
                m_lk[h] = 1'b1;
            end
        gfc_host_model_i.access(wr, rd, dw, be, wd, r);
        chk({31'h0, r.valid}, 32'h1);
        chk({31'h0, r.claimed}, {31'h0, dw inside {6'h03, 6'h04, 6'h05, 6'h0b}});
        chk(r.rdata, e);
        chk(gbase, m_rd(6'h04));
        chk(wbase, m_rd(6'h05));
        chk({subsystem_ident, smk}, m_sub);
        chk({30'h0, lk}, {30'h0, m_lk});
    endtask

    task automatic mem(input logic [31:0] a, input logic v, input logic e);
        logic ah, wh;
        @(negedge clk);
        mreq = '{valid: v, addr: a};
        en = e;
        ah = v && e && a[31:26] == m_gb && (!m_sel || a[25] == m_b25);
        wh = v && e && a[31:19] == m_wb;
        @(negedge clk);
        mreq = '{valid: 1'b0, addr: ~a};
        chk({30'h0, hit}, {30'h0, ah, wh});
    endtask

    task automatic do_reset();
        rst = 1'b1;
        m_gb = '0;
        m_b25 = 1'b0;
        m_wb = '0;
        m_sub = '0;
        m_lk = '0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk(gbase, 32'h00000008);
        chk(wbase, 32'h00000000);
        chk({subsystem_ident, smk}, 32'h0);
        chk({30'h0, lk}, 32'h0);
    endtask

    // --------------------------------
    // Clock, watchdog and tests
    // --------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        final_report();
    end

    initial begin
        logic [5:0] dws[$];
        logic [31:0] a, b;
        dws = '{6'h00, 6'h03, 6'h04, 6'h05, 6'h0b, 6'h0c, 6'h3f};
        a = $urandom(32'h05c1);
        sel = 1'b0;
        m_sel = 1'b0;
        en = 1'b1;
        mreq = '0;
        do_reset();
        acc(1'b1, 1'b0, 6'h0b, 4'h1, 32'h12345678);
        acc(1'b1, 1'b0, 6'h0b, 4'hf, 32'h9abcdef0);
        acc(1'b0, 1'b1, 6'h0b, 4'hf, 32'h0);
        for (int s = 0; s < 4; s++) begin
            @(negedge clk);
            sel = s[0];
            m_sel = s[0];
            repeat (2) @(negedge clk);
            chk({31'h0, ap32}, {31'h0, m_sel});
            acc(1'b1, 1'b0, 6'h04, 4'hf, 32'hffffffff);
            acc(1'b1, 1'b0, 6'h05, 4'hf, 32'hffffffff);
            acc(1'b1, 1'b1, 6'h03, 4'hf, 32'hffffffff);
            acc(1'b0, 1'b1, 6'h03, 4'hf, 32'h0);
            for (int i = 0; i < 60; i++) begin
                a = $urandom;
                b = $urandom;
                acc(a[0], a[1] | !a[0], dws[$urandom_range(6)], a[7:4], $urandom);
                mem(a[8] ? {m_gb, b[25:0]} : a[9] ? {m_wb, b[18:0]} : b, |a[11:10], |a[13:12]);
            end
            if (s == 1) do_reset();
        end
        final_report();
    end
endmodule // test_graphics_function_config_header

`default_nettype wire
